// File: pao_pkg.sv
// constants, field layouts and carrier types of the phase accumulator
// What this block does
// R1 - each selected-clock rising edge loads accumulator with accumulator plus buffered increment
// R2 - accumulator is 20 bits, reached as low, high and upper-nibble bytes
// R3 - increment is 16 bits held in low and high byte registers
// R4 - enabled: shadow buffer loads on second clock edge after low-byte write
// R5 - disabled: increment writes reach the shadow buffer at once
// R6 - software writes high increment byte before low increment byte
// R7 - accumulator carry is the raw output, rate is clock times increment over 2^20
// R8 - toggle mode flips the output on every overflow
// R9 - pulse mode drives output active right after overflow for the chosen width
// R10 - pulse width field selects 2^code oscillator clock periods, 1 to 128
// R11 - control bit 0 selects pulse mode; width field matters only there
// R12 - software keeps pulse width shorter than the overflow period
// R13 - polarity bit 4 inverts the output as the final stage
// R14 - a polarity change with interrupt enabled raises an interrupt
// R15 - read-only bit 5 shows the output level, also sent to peripherals
// R16 - bit 6 connects the output to its pin
// R17 - bit 7 enables the block; bits 3 to 1 read zero
// R18 - clock source field: 11 logic cell, 10 fast oscillator, 01 system, 00 pin
// R19 - overflow sets the flag; interrupt needs all four enables; software clears
// R20 - every register of the block resets to zero
// R21 - block runs in sleep; fast oscillator kept on when enabled and selected
// R22 - one overflow event per carry out of accumulator bit 19
package pao_pkg;

  // ************************************************************
  // register map, byte addresses of aligned words
  // ************************************************************
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_CLOCK_SELECT = 8'h04;
  localparam logic [7:0] OFS_ACC_LOW = 8'h08;
  localparam logic [7:0] OFS_ACC_HIGH = 8'h0C;
  localparam logic [7:0] OFS_ACC_UPPER = 8'h10;
  localparam logic [7:0] OFS_INC_LOW = 8'h14;
  localparam logic [7:0] OFS_INC_HIGH = 8'h18;
  localparam logic [7:0] OFS_IRQ = 8'h1C;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int CTL_PFM = 0;
  localparam int CTL_POL = 4;
  localparam int CTL_OUT = 5;
  localparam int CTL_OE = 6;
  localparam int CTL_EN = 7;
  localparam int CLK_CKS_LO = 0;
  localparam int CLK_PWS_LO = 5;
  localparam int IRQ_FLAG = 0;
  localparam int IRQ_IE = 1;
  localparam int IRQ_PERIPHERAL_INTERRUPT_ENABLE = 2;
  localparam int IRQ_GIE = 3;

  localparam int ACC_W = 20;
  localparam int INC_W = 16;
  localparam int PWS_W = 3;
  localparam logic [1:0] PEND_IDLE = 2'h0;
  localparam logic [1:0] PEND_ARMED = 2'h1;
  localparam logic [1:0] PEND_ONE = 2'h2;
  localparam int unsigned CLK_HZ = 10_000_000;

  typedef enum logic [1:0] {
    PAO_SRC_PIN = 2'h0,
    PAO_SRC_SYS = 2'h1,
    PAO_SRC_FAST = 2'h2,
    PAO_SRC_CELL = 2'h3
  } pao_src_e;

  typedef struct packed {
    logic enable;
    logic pin_oe;
    logic polarity;
    logic pulse_mode;
  } pao_ctrl_s;

  typedef struct packed {
    logic [PWS_W-1:0] pulse_width;
    pao_src_e source;
  } pao_clksel_s;

  typedef struct packed {
    logic ie;
    logic peripheral_interrupt_enable;
    logic global_interrupt_enable;
  } pao_irqen_s;

endpackage

// File: pao_core.sv
// phase accumulator oscillator with apb register slave
module pao_core #(
  parameter int ACC_W = pao_pkg::ACC_W,
  parameter int INC_W = pao_pkg::INC_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_clock_pin,
  input wire logic internal_fast_oscillator,
  input wire logic logic_cell_output,
  output logic osc_out,
  output logic osc_pin_o,
  output logic osc_pin_oe,
  output logic overflow_irq,
  output logic fast_osc_keep_on
);

  // ************************************************************
  // elaboration checks
  // ************************************************************
  if (ACC_W != 20 || INC_W != 16) begin : g_bad_width
    $error("byte register layout serves only a 20-bit accumulator");
  end

  // ************************************************************
  // register state
  // ************************************************************
  pao_pkg::pao_ctrl_s ctrl_q;
  pao_pkg::pao_clksel_s clksel_q;
  pao_pkg::pao_irqen_s irqen_q;
  logic flag_q;
  logic [ACC_W-1:0] acc_q;
  logic [INC_W-1:0] inc_q;
  logic [INC_W-1:0] shadow_q;
  logic [1:0] pend_q;
  logic src_prev_q;
  logic ovf_q;
  logic toggle_q;
  logic pulse_q;
  logic [7:0] pulse_cnt_q;
  logic level_q;

  // ************************************************************
  // apb access decode
  // ************************************************************
  logic access;
  logic wr;
  logic mapped;
  logic [7:0] wbyte;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  assign access = psel && penable && pready;
  assign wr = access && pwrite && mapped;
  assign wbyte = pwdata[7:0];
  assign mapped = hit(paddr, pao_pkg::OFS_CONTROL) ||
                  hit(paddr, pao_pkg::OFS_CLOCK_SELECT) ||
                  hit(paddr, pao_pkg::OFS_ACC_LOW) ||
                  hit(paddr, pao_pkg::OFS_ACC_HIGH) ||
                  hit(paddr, pao_pkg::OFS_ACC_UPPER) ||
                  hit(paddr, pao_pkg::OFS_INC_LOW) ||
                  hit(paddr, pao_pkg::OFS_INC_HIGH) ||
                  hit(paddr, pao_pkg::OFS_IRQ);

  logic [7:0] rbyte;
  logic [23:0] acc_ext;
  assign acc_ext = 24'(acc_q);

  always_comb begin
    rbyte = 8'h00;
    case (paddr)
      pao_pkg::OFS_CONTROL: begin
        // bits 3..1 left at zero
        rbyte[pao_pkg::CTL_EN] = ctrl_q.enable; // R17
        rbyte[pao_pkg::CTL_OE] = ctrl_q.pin_oe;
        rbyte[pao_pkg::CTL_OUT] = level_q; // R15
        rbyte[pao_pkg::CTL_POL] = ctrl_q.polarity;
        rbyte[pao_pkg::CTL_PFM] = ctrl_q.pulse_mode;
      end
      pao_pkg::OFS_CLOCK_SELECT: begin
        rbyte[pao_pkg::CLK_PWS_LO +: pao_pkg::PWS_W] = clksel_q.pulse_width;
        rbyte[pao_pkg::CLK_CKS_LO +: 2] = clksel_q.source;
      end
      pao_pkg::OFS_ACC_LOW: rbyte = acc_ext[7:0]; // R2
      pao_pkg::OFS_ACC_HIGH: rbyte = acc_ext[15:8];
      pao_pkg::OFS_ACC_UPPER: rbyte = {4'h0, acc_ext[19:16]};
      pao_pkg::OFS_INC_LOW: rbyte = inc_q[7:0]; // R3
      pao_pkg::OFS_INC_HIGH: rbyte = inc_q[15:8];
      pao_pkg::OFS_IRQ: begin
        rbyte[pao_pkg::IRQ_FLAG] = flag_q;
        rbyte[pao_pkg::IRQ_IE] = irqen_q.ie;
        rbyte[pao_pkg::IRQ_PERIPHERAL_INTERRUPT_ENABLE] = irqen_q.peripheral_interrupt_enable;
        rbyte[pao_pkg::IRQ_GIE] = irqen_q.global_interrupt_enable;
      end
      default: rbyte = 8'h00;
    endcase
  end

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      prdata <= {24'h00_0000, rbyte};
      pslverr <= psel && penable && !pready && !mapped;
    end
  end

  // ************************************************************
  // control registers
  // ************************************************************
  logic pol_flip;
  assign pol_flip = wr && hit(paddr, pao_pkg::OFS_CONTROL) &&
                    (wbyte[pao_pkg::CTL_POL] != ctrl_q.polarity);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= '0; // R20
      clksel_q <= '0;
      irqen_q <= '0;
    end else if (wr) begin
      if (hit(paddr, pao_pkg::OFS_CONTROL)) begin
        ctrl_q.enable <= wbyte[pao_pkg::CTL_EN]; // R17
        ctrl_q.pin_oe <= wbyte[pao_pkg::CTL_OE]; // R16
        ctrl_q.polarity <= wbyte[pao_pkg::CTL_POL]; // R13
        ctrl_q.pulse_mode <= wbyte[pao_pkg::CTL_PFM]; // R11
      end
      if (hit(paddr, pao_pkg::OFS_CLOCK_SELECT)) begin
        clksel_q.pulse_width <=
          wbyte[pao_pkg::CLK_PWS_LO +: pao_pkg::PWS_W]; // R10
        clksel_q.source <=
          pao_pkg::pao_src_e'(wbyte[pao_pkg::CLK_CKS_LO +: 2]); // R18
      end
      if (hit(paddr, pao_pkg::OFS_IRQ)) begin
        irqen_q.ie <= wbyte[pao_pkg::IRQ_IE];
        irqen_q.peripheral_interrupt_enable <= wbyte[pao_pkg::IRQ_PERIPHERAL_INTERRUPT_ENABLE];
        irqen_q.global_interrupt_enable <= wbyte[pao_pkg::IRQ_GIE];
      end
    end
  end

  // ************************************************************
  // oscillator clock selection
  // ************************************************************
  logic src_level;
  logic tick;

  always_comb begin
    case (clksel_q.source) // R18
      pao_pkg::PAO_SRC_PIN: src_level = external_clock_pin;
      pao_pkg::PAO_SRC_FAST: src_level = internal_fast_oscillator;
      pao_pkg::PAO_SRC_CELL: src_level = logic_cell_output;
      default: src_level = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src_prev_q <= 1'b0;
    end else begin
      src_prev_q <= src_level;
    end
  end

  // system clock source advances on every edge; others on a sampled rise
  assign tick = ctrl_q.enable &&
                ((clksel_q.source == pao_pkg::PAO_SRC_SYS) ||
                 (src_level && !src_prev_q));

  // ************************************************************
  // increment and shadow buffer
  // ************************************************************
  logic inc_lo_wr;
  logic inc_hi_wr;
  assign inc_lo_wr = wr && hit(paddr, pao_pkg::OFS_INC_LOW);
  assign inc_hi_wr = wr && hit(paddr, pao_pkg::OFS_INC_HIGH);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      inc_q <= '0; // R20
    end else begin
      if (inc_lo_wr) begin
        inc_q[7:0] <= wbyte; // R3
      end
      if (inc_hi_wr) begin
        inc_q[15:8] <= wbyte;
      end
    end
  end

  // high byte must already be in place when the low byte arms the load
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= pao_pkg::PEND_IDLE;
      shadow_q <= '0;
    end else if (!ctrl_q.enable) begin
      pend_q <= pao_pkg::PEND_IDLE;
      shadow_q <= inc_q; // R5
    end else if (inc_lo_wr) begin
      pend_q <= pao_pkg::PEND_ARMED; // R6
    end else if (tick && pend_q == pao_pkg::PEND_ARMED) begin
      pend_q <= pao_pkg::PEND_ONE;
    end else if (tick && pend_q == pao_pkg::PEND_ONE) begin
      pend_q <= pao_pkg::PEND_IDLE;
      shadow_q <= inc_q; // R4
    end
  end

  // ************************************************************
  // accumulator
  // ************************************************************
  logic [ACC_W:0] sum;
  assign sum = {1'b0, acc_q} + {{(ACC_W + 1 - INC_W){1'b0}}, shadow_q}; // R7

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= '0;
      ovf_q <= 1'b0;
    end else begin
      ovf_q <= tick && sum[ACC_W]; // R22
      if (wr && hit(paddr, pao_pkg::OFS_ACC_LOW)) begin
        acc_q[7:0] <= wbyte; // R2
      end else if (wr && hit(paddr, pao_pkg::OFS_ACC_HIGH)) begin
        acc_q[15:8] <= wbyte;
      end else if (wr && hit(paddr, pao_pkg::OFS_ACC_UPPER)) begin
        acc_q[19:16] <= wbyte[3:0];
      end else if (tick) begin
        acc_q <= sum[ACC_W-1:0]; // R1
      end
    end
  end

  // ************************************************************
  // output shaping
  // ************************************************************
  logic carry;
  logic [7:0] width_m1;
  assign carry = tick && sum[ACC_W];
  assign width_m1 = 8'((9'h001 << clksel_q.pulse_width) - 9'h001); // R10

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      toggle_q <= 1'b0;
    end else if (!ctrl_q.enable) begin
      toggle_q <= 1'b0;
    end else if (carry) begin
      toggle_q <= !toggle_q; // R8
    end
  end

  // width counted in oscillator clock periods, not system clocks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_q <= 1'b0;
      pulse_cnt_q <= 8'h00;
    end else if (!ctrl_q.enable) begin
      pulse_q <= 1'b0;
      pulse_cnt_q <= 8'h00;
    end else if (carry) begin
      pulse_q <= 1'b1; // R9
      pulse_cnt_q <= width_m1;
    end else if (tick && pulse_q) begin
      if (pulse_cnt_q == 8'h00) begin
        pulse_q <= 1'b0;
      end else begin
        pulse_cnt_q <= pulse_cnt_q - 8'h01;
      end
    end
  end

  logic level_d;
  assign level_d = (ctrl_q.pulse_mode ? pulse_q : toggle_q) ^
                   ctrl_q.polarity; // R13

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_q <= 1'b0;
      osc_out <= 1'b0;
      osc_pin_o <= 1'b0;
      osc_pin_oe <= 1'b0;
      fast_osc_keep_on <= 1'b0;
    end else begin
      level_q <= level_d; // R15
      osc_out <= level_d;
      osc_pin_o <= level_d;
      osc_pin_oe <= ctrl_q.pin_oe; // R16
      fast_osc_keep_on <= ctrl_q.enable &&
        (clksel_q.source == pao_pkg::PAO_SRC_FAST); // R21
    end
  end

  // ************************************************************
  // overflow flag and interrupt
  // ************************************************************
  logic flag_clr;
  logic flag_set;
  assign flag_clr = wr && hit(paddr, pao_pkg::OFS_IRQ) &&
                    wbyte[pao_pkg::IRQ_FLAG];
  assign flag_set = ovf_q || (pol_flip && irqen_q.ie); // R14

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
      overflow_irq <= 1'b0;
    end else begin
      if (flag_set) begin
        flag_q <= 1'b1; // R19
      end else if (flag_clr) begin
        flag_q <= 1'b0;
      end
      overflow_irq <= flag_q && ctrl_q.enable && irqen_q.ie &&
                      irqen_q.peripheral_interrupt_enable && irqen_q.global_interrupt_enable; // R19
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  sequence s_lo_write;
    inc_lo_wr && ctrl_q.enable;
  endsequence

  a_acc_adds: assert property (@(posedge clk) disable iff (!rst_n) // R1
    (tick && !wr) |=> acc_q == $past(sum[ACC_W-1:0]))
    else $error("accumulator did not add the buffered increment");

  a_carry_event: assert property (@(posedge clk) disable iff (!rst_n) // R22
    (tick && sum[ACC_W]) |=> ovf_q ##1 (!ovf_q || $past(carry)))
    else $error("overflow event not one per carry");

  a_shadow_hold: assert property (@(posedge clk) disable iff (!rst_n) // R4
    s_lo_write ##1 (!tick && ctrl_q.enable && !inc_lo_wr)
      |=> $stable(shadow_q))
    else $error("shadow loaded before second oscillator edge");

  a_shadow_direct: assert property (@(posedge clk) disable iff (!rst_n) // R5
    !ctrl_q.enable |=> shadow_q == $past(inc_q))
    else $error("disabled shadow buffer not loaded at once");

  a_toggle_flip: assert property (@(posedge clk) disable iff (!rst_n) // R8
    (carry && ctrl_q.enable) |=> toggle_q != $past(toggle_q))
    else $error("toggle output did not flip on overflow");

  a_pulse_start: assert property (@(posedge clk) disable iff (!rst_n) // R9
    carry |=> pulse_q && pulse_cnt_q == $past(width_m1))
    else $error("pulse not started with selected width");

  a_level_pol: assert property (@(posedge clk) disable iff (!rst_n) // R13
    1'b1 |=> level_q == (($past(ctrl_q.pulse_mode) ? $past(pulse_q)
      : $past(toggle_q)) ^ $past(ctrl_q.polarity)))
    else $error("output level does not follow mode and polarity");

  a_flag_set: assert property (@(posedge clk) disable iff (!rst_n) // R19
    ovf_q |=> flag_q)
    else $error("overflow did not set the flag");

  a_irq_gate: assert property (@(posedge clk) disable iff (!rst_n) // R19
    overflow_irq |-> $past(flag_q) && $past(ctrl_q.enable) &&
      $past(irqen_q.ie) && $past(irqen_q.peripheral_interrupt_enable) && $past(irqen_q.global_interrupt_enable))
    else $error("interrupt raised without flag and enables");

  a_pol_irq: assert property (@(posedge clk) disable iff (!rst_n) // R14
    (pol_flip && irqen_q.ie) |=> flag_q)
    else $error("polarity change did not raise the flag");

  a_pin_oe: assert property (@(posedge clk) disable iff (!rst_n) // R16
    osc_pin_oe |-> $past(ctrl_q.pin_oe))
    else $error("pin driven while output enable clear");

endmodule

// File: pao_far_model.sv
// far side model: oscillator clock sources and the output pin
module pao_far_model #(
  parameter int PIN_HALF = 4,
  parameter int FAST_HALF = 2,
  parameter int CELL_HALF = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic osc_pin_o,
  input wire logic osc_pin_oe,
  output logic pin_clk,
  output logic fast_clk,
  output logic cell_clk,
  output logic pin_level
);
  timeunit 1ns;
  timeprecision 1ns;
  int cp;
  int cf;
  int cc;

  // ************************************************************
  // source clocks, slower than clk so every rising edge is seen
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cp <= 0;
      cf <= 0;
      cc <= 0;
      pin_clk <= 1'b0;
      fast_clk <= 1'b0;
      cell_clk <= 1'b0;
    end else begin
      cp <= (cp == PIN_HALF - 1) ? 0 : cp + 1;
      cf <= (cf == FAST_HALF - 1) ? 0 : cf + 1;
      cc <= (cc == CELL_HALF - 1) ? 0 : cc + 1;
      if (cp == PIN_HALF - 1) pin_clk <= ~pin_clk;
      if (cf == FAST_HALF - 1) fast_clk <= ~fast_clk;
      if (cc == CELL_HALF - 1) cell_clk <= ~cell_clk;
    end
  end

  // pin has a pull-down, so a released pin reads low
  assign pin_level = osc_pin_oe ? osc_pin_o : 1'b0;
endmodule

// File: testbench.sv
// self-checking testbench of the phase accumulator oscillator
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PH = 4;
  localparam int FH = 2;
  localparam int CH = 3;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pin_clk;
  logic fast_clk;
  logic cell_clk;
  logic osc_out;
  logic osc_pin_o;
  logic osc_pin_oe;
  logic overflow_irq;
  logic keep_on;
  logic pin_level;
  logic [31:0] rdat;
  logic rerr;
  int num_errors = 0;
  int tests_run = 0;
  int n;
  int src_tab [3] = '{0, 2, 3};
  int half_tab [3] = '{PH, FH, CH};

  always #50 clk = ~clk;

  pao_core u_dut (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .external_clock_pin(pin_clk),
    .internal_fast_oscillator(fast_clk), .logic_cell_output(cell_clk),
    .osc_out(osc_out), .osc_pin_o(osc_pin_o), .osc_pin_oe(osc_pin_oe),
    .overflow_irq(overflow_irq), .fast_osc_keep_on(keep_on)
  );

  pao_far_model #(.PIN_HALF(PH), .FAST_HALF(FH), .CELL_HALF(CH)) u_far (
    .clk(clk), .rst_n(rst_n), .osc_pin_o(osc_pin_o),
    .osc_pin_oe(osc_pin_oe), .pin_clk(pin_clk), .fast_clk(fast_clk),
    .cell_clk(cell_clk), .pin_level(pin_level)
  );

  // ************************************************************
  // compare, bus and measurement tasks
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_n(input int got, input int exp);
    tests_run++;
    if (got != exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    // no cycle count assumed; a hang is ended by the watchdog
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 8'h00);
    chk(rdat, exp);
  endtask

  // length of the second full run at level lvl, first may be partial
  task automatic meas(input logic lvl, input int exp);
    int i;
    for (int r = 0; r < 2; r++) begin
      i = 0;
      while (osc_out !== ~lvl && i < 9000) begin
        @(posedge clk);
        i++;
      end
      while (osc_out !== lvl && i < 18000) begin
        @(posedge clk);
        i++;
      end
      n = 0;
      while (osc_out === lvl && n < 9000) begin
        @(posedge clk);
        n++;
      end
    end
    chk_n(n, exp);
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (80000) @(posedge clk);
    num_errors++;
    end_of_test;
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int a = 0; a < 32; a += 4) rd(8'(a), 32'h0);
    apb(1'b0, 8'h20, 8'h00);
    chk({31'h0, rerr}, 32'h1);
    chk(rdat, 32'h0);
    // disabled with polarity set: inverted idle level shows high
    wr(pao_pkg::OFS_CONTROL, 8'h5F);
    rd(pao_pkg::OFS_CONTROL, 32'h71);
    chk({31'h0, osc_out}, 32'h1);
    chk({30'h0, osc_pin_oe, pin_level}, 32'h3);
    wr(pao_pkg::OFS_CONTROL, 8'h00);
    rd(pao_pkg::OFS_CONTROL, 32'h00);
    chk({31'h0, pin_level}, 32'h0);
    wr(pao_pkg::OFS_CLOCK_SELECT, 8'hFF);
    rd(pao_pkg::OFS_CLOCK_SELECT, 32'hE3);
    wr(pao_pkg::OFS_ACC_UPPER, 8'hFF);
    rd(pao_pkg::OFS_ACC_UPPER, 32'h0F);
    wr(pao_pkg::OFS_ACC_LOW, 8'hA5);
    rd(pao_pkg::OFS_ACC_LOW, 32'hA5);
    wr(pao_pkg::OFS_ACC_HIGH, 8'h5A);
    rd(pao_pkg::OFS_ACC_HIGH, 32'h5A);
    wr(pao_pkg::OFS_INC_HIGH, 8'h12);
    rd(pao_pkg::OFS_INC_HIGH, 32'h12);
    wr(pao_pkg::OFS_INC_LOW, 8'h34);
    rd(pao_pkg::OFS_INC_LOW, 32'h34);
    // toggle mode, first increment loaded while disabled
    wr(pao_pkg::OFS_CLOCK_SELECT, 8'h01);
    for (int j = 0; j < 3; j++) begin
      wr(pao_pkg::OFS_INC_HIGH, 8'h80 >> j);
      wr(pao_pkg::OFS_INC_LOW, 8'h00);
      if (j == 0) wr(pao_pkg::OFS_CONTROL, 8'h80);
      meas(1'b1, (1 << pao_pkg::ACC_W) / ((32'h80 >> j) << 8));
    end
    // gated interrupt
    wr(pao_pkg::OFS_IRQ, 8'h0E);
    n = 0;
    while (overflow_irq !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, overflow_irq}, 32'h1);
    wr(pao_pkg::OFS_IRQ, 8'h06);
    repeat (2) @(posedge clk);
    chk({31'h0, overflow_irq}, 32'h0);
    wr(pao_pkg::OFS_CONTROL, 8'h00);
    wr(pao_pkg::OFS_IRQ, 8'h07);
    rd(pao_pkg::OFS_IRQ, 32'h06);
    wr(pao_pkg::OFS_CONTROL, 8'h10);
    repeat (3) @(posedge clk);
    rd(pao_pkg::OFS_IRQ, 32'h07);
    wr(pao_pkg::OFS_IRQ, 8'h07);
    // pulse mode, period 512 keeps every width shorter
    wr(pao_pkg::OFS_INC_HIGH, 8'h08);
    wr(pao_pkg::OFS_INC_LOW, 8'h00);
    wr(pao_pkg::OFS_CONTROL, 8'h81);
    for (int c = 0; c < 8; c++) begin
      wr(pao_pkg::OFS_CLOCK_SELECT, {3'(c), 5'h01});
      meas(1'b1, 1 << c);
    end
    chk({31'h0, keep_on}, 32'h0);
    wr(pao_pkg::OFS_CONTROL, 8'h91);
    meas(1'b0, 128);
    // other clock sources in toggle mode
    wr(pao_pkg::OFS_CONTROL, 8'h00);
    wr(pao_pkg::OFS_INC_HIGH, 8'h80);
    wr(pao_pkg::OFS_INC_LOW, 8'h00);
    for (int s = 0; s < 3; s++) begin
      wr(pao_pkg::OFS_CLOCK_SELECT, 8'(src_tab[s]));
      wr(pao_pkg::OFS_CONTROL, 8'h80);
      // same value again, now armed while enabled on a slow source
      wr(pao_pkg::OFS_INC_LOW, 8'h00);
      meas(1'b1, 64 * half_tab[s]);
      chk({31'h0, keep_on}, {31'h0, src_tab[s] == 2});
    end
    end_of_test;
  end
endmodule
